//--- logic/rfl_capture.sv
`timescale 1ns/1ns
// Peak and threshold capture over qualified converter samples.
module rfl_capture #(
   parameter int SAMPLE_WIDTH = 8
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic clear,
   input wire rfl_pkg::rfl_sample_t sample,
   input wire logic min_mode,
   input wire logic signed [SAMPLE_WIDTH-1:0] threshold,
   output logic peak_seen,
   output logic signed [SAMPLE_WIDTH-1:0] peak_value,
   output logic [7:0] peak_time,
   output logic threshold_seen,
   output logic [7:0] threshold_time
);

   // Refuse any width but the 8-bit sample that the struct carries.
   if (SAMPLE_WIDTH != 8) begin : g_width_check
      $error("rfl_capture serves 8-bit samples only");
   end

   // Signed copy of the sample, so every compare below is a signed one.
   wire logic signed [SAMPLE_WIDTH-1:0] sample_value = sample.value;

   // A sample beats the held peak only when strictly better, so ties keep the earliest time.
   wire logic better_max = sample_value > peak_value;
   wire logic better_min = sample_value < peak_value;
   wire logic better = !peak_seen || (min_mode ? better_min : better_max);
   wire logic beyond = min_mode ? (sample_value < threshold) : (sample_value > threshold);
   wire logic take_peak = sample.valid && better;
   wire logic take_threshold = sample.valid && !threshold_seen && beyond;

   // Peak tracker; cleared at each launch and held until the next one.
   always_ff @(posedge clock) begin
      if (srst || clear) begin
         peak_seen <= 1'b0;
         peak_value <= '0;
         peak_time <= 8'h00;
      end else if (take_peak) begin
         peak_seen <= 1'b1;
         peak_value <= sample_value;
         peak_time <= sample.time_stamp;
      end
   end

   // Threshold tracker keeps only the first crossing.
   always_ff @(posedge clock) begin
      if (srst || clear) begin
         threshold_seen <= 1'b0;
         threshold_time <= 8'h00;
      end else if (take_threshold) begin
         threshold_seen <= 1'b1;
         threshold_time <= sample.time_stamp;
      end
   end

endmodule

//--- logic/rfl_diag.sv
`timescale 1ns/1ns
module rfl_diag #(
   parameter int SAMPLE_WIDTH = 8
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [4:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   input wire logic sample_valid,
   input wire logic signed [SAMPLE_WIDTH-1:0] tx_pair_sample,
   input wire logic signed [SAMPLE_WIDTH-1:0] rx_pair_sample,
   input wire logic signed [SAMPLE_WIDTH-1:0] threshold_level,
   output logic driver_takeover,
   output logic pulse_on_rx_pair,
   output logic slow_line_driver,
   output logic fast_line_driver,
   output logic pulse_negative,
   output logic monitor_busy
);

   // The capture compares and the result layouts are built for 8-bit converter samples.
   if (SAMPLE_WIDTH != 8) begin : g_width_check
      $error("rfl_diag serves 8-bit converter samples only");
   end

   // Run state; one run covers 256 sample times after the launch.
   typedef enum logic [1:0] {
      RFL_IDLE,
      RFL_RUN
   } rfl_state_t;

   // Cycle counts of the slow link pulse, cut to the counter width on purpose.
   localparam logic [3:0] SLOW_SHORT_COUNT = 4'(rfl_pkg::SLOW_SHORT_CYCLES);
   localparam logic [3:0] SLOW_LONG_COUNT = 4'(rfl_pkg::SLOW_LONG_CYCLES);
   localparam logic [7:0] LAST_TIME = 8'(rfl_pkg::LAST_SAMPLE_TIME);

   // Pulls the decoded control fields out of a register image.
   function automatic rfl_pkg::rfl_ctrl_t decode_ctrl(input logic [15:0] word);
      rfl_pkg::rfl_ctrl_t c;
      c.enable = word[rfl_pkg::CTRL_ENABLE_BIT];
      c.fast_driver_select = word[rfl_pkg::CTRL_FAST_DRIVER_SELECT_BIT];
      c.pulse_rx_pair = word[rfl_pkg::CTRL_PULSE_RX_PAIR_BIT];
      c.monitor_rx_pair = word[rfl_pkg::CTRL_MONITOR_RX_PAIR_BIT];
      c.width = word[rfl_pkg::CTRL_WIDTH_HI:rfl_pkg::CTRL_WIDTH_LO];
      c.min_mode = word[rfl_pkg::CTRL_MIN_MODE_BIT];
      return c;
   endfunction

   // Builds the register image of a control struct with the busy flag in the send position.
   function automatic logic [15:0] encode_ctrl(input rfl_pkg::rfl_ctrl_t c, input logic busy);
      logic [15:0] word;
      word = 16'h0000;
      word[rfl_pkg::CTRL_ENABLE_BIT] = c.enable;
      word[rfl_pkg::CTRL_FAST_DRIVER_SELECT_BIT] = c.fast_driver_select;
      word[rfl_pkg::CTRL_PULSE_RX_PAIR_BIT] = c.pulse_rx_pair;
      word[rfl_pkg::CTRL_MONITOR_RX_PAIR_BIT] = c.monitor_rx_pair;
      word[rfl_pkg::CTRL_SEND_BIT] = busy;
      word[rfl_pkg::CTRL_WIDTH_HI:rfl_pkg::CTRL_WIDTH_LO] = c.width;
      word[rfl_pkg::CTRL_MIN_MODE_BIT] = c.min_mode;
      return word;
   endfunction

   // Stored register fields and run state.
   rfl_pkg::rfl_ctrl_t ctrl;
   logic [7:0] win_start;
   logic [7:0] win_stop;
   rfl_state_t state;
   rfl_state_t next_state;
   logic [7:0] timer;
   logic [3:0] pulse_count;
   logic pulse_active;
   logic fast_polarity;
   logic [15:0] next_rdata;

   // Register decode.
   wire logic write_control = reg_write && (reg_addr == rfl_pkg::REFLECT_CONTROL_ADDR);
   wire logic write_window = reg_write && (reg_addr == rfl_pkg::REFLECT_WINDOW_ADDR);
   wire rfl_pkg::rfl_ctrl_t written_ctrl = decode_ctrl(reg_wdata);
   wire logic send_request = write_control && reg_wdata[rfl_pkg::CTRL_SEND_BIT];

   // Enable as it stands after this clock edge.
   function automatic logic next_ctrl_enable();
      return write_control ? written_ctrl.enable : ctrl.enable;
   endfunction

   // A disable must release the drivers on the same edge that drops the takeover, or the
   // line would carry a stray cycle of test pulse after the transceiver got it back.
   wire logic enable_next = next_ctrl_enable();

   // A send is honoured only with the unit enabled and no run in progress; a send written
   // during a run is dropped so the running capture is not torn in half.
   wire logic launch = send_request && written_ctrl.enable && (state == RFL_IDLE);
   wire logic running = (state == RFL_RUN);

   // Pulse length: slow driver uses the fixed 50/100 ns link pulse, fast driver counts 8 ns samples.
   wire logic slow_long = written_ctrl.width[2];
   wire logic [3:0] slow_count = slow_long ? SLOW_LONG_COUNT : SLOW_SHORT_COUNT;
   wire logic [3:0] fast_count = {1'b0, written_ctrl.width};
   wire logic width_zero = (written_ctrl.width == 3'b000);
   wire logic [3:0] launch_count = written_ctrl.fast_driver_select ? fast_count : slow_count;

   // The slow pulse ticks on every clock, the fast pulse on every converter sample.
   wire logic pulse_tick = ctrl.fast_driver_select ? sample_valid : 1'b1;
   wire logic pulse_last = pulse_active && pulse_tick && (pulse_count == 4'h1);

   // Monitor input: pair select, then the window qualifier on the launch-relative timer.
   wire logic signed [SAMPLE_WIDTH-1:0] picked_sample =
      ctrl.monitor_rx_pair ? rx_pair_sample : tx_pair_sample;
   wire logic in_window = (timer >= win_start) && (timer <= win_stop);
   wire logic last_sample = running && sample_valid && (timer == LAST_TIME);
   wire rfl_pkg::rfl_sample_t qualified = '{
      valid: running && sample_valid && in_window,
      time_stamp: timer,
      value: picked_sample
   };

   // Capture results.
   wire logic peak_seen;
   wire logic signed [SAMPLE_WIDTH-1:0] peak_value;
   wire logic [7:0] peak_time;
   wire logic threshold_seen;
   wire logic [7:0] threshold_time;

   // Capture unit; its results are cleared by the launch itself.
   rfl_capture #(
      .SAMPLE_WIDTH(SAMPLE_WIDTH)
   ) u_capture (
      .clock(clock),
      .srst(srst),
      .clear(launch),
      .sample(qualified),
      .min_mode(ctrl.min_mode),
      .threshold(threshold_level),
      .peak_seen(peak_seen),
      .peak_value(peak_value),
      .peak_time(peak_time),
      .threshold_seen(threshold_seen),
      .threshold_time(threshold_time)
   );

   // Result register images.
   wire logic [15:0] peak_word = {peak_time, peak_value};
   wire logic [15:0] threshold_word = {threshold_seen, 7'h00, threshold_time};

   // Read data selection; unmapped addresses read as zero.
   always_comb begin
      case (reg_addr)
         rfl_pkg::REFLECT_CONTROL_ADDR: next_rdata = encode_ctrl(ctrl, running);
         rfl_pkg::REFLECT_WINDOW_ADDR: next_rdata = {win_start, win_stop};
         rfl_pkg::REFLECT_PEAK_RESULT_ADDR: next_rdata = peak_word;
         rfl_pkg::REFLECT_THRESHOLD_RESULT_ADDR: next_rdata = threshold_word;
         default: next_rdata = 16'h0000;
      endcase
   end

   // Read data is registered on the read strobe and held until the next read.
   // A result read therefore shows the value that stood at the edge taking the strobe.
   always_ff @(posedge clock) begin
      if (srst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end
   end

   // Control register; the send bit is a strobe and is not stored.
   always_ff @(posedge clock) begin
      if (srst) begin
         ctrl <= decode_ctrl(rfl_pkg::CONTROL_RESET);
      end else if (write_control) begin
         ctrl <= written_ctrl;
      end
   end

   // Window register, full range after reset.
   always_ff @(posedge clock) begin
      if (srst) begin
         win_start <= rfl_pkg::WIN_START_RESET;
         win_stop <= rfl_pkg::WIN_STOP_RESET;
      end else if (write_window) begin
         win_start <= reg_wdata[rfl_pkg::WIN_START_HI:rfl_pkg::WIN_START_LO];
         win_stop <= reg_wdata[rfl_pkg::WIN_STOP_HI:rfl_pkg::WIN_STOP_LO];
      end
   end

   // Run sequencing: one run covers sample times 0 through 255 after the launch.
   always_comb begin
      next_state = state;
      case (state)
         RFL_IDLE: begin
            if (launch) begin
               next_state = RFL_RUN;
            end
         end
         RFL_RUN: begin
            if (last_sample || !ctrl.enable) begin
               next_state = RFL_IDLE;
            end
         end
         default: next_state = RFL_IDLE;
      endcase
   end

   // State register.
   always_ff @(posedge clock) begin
      if (srst) begin
         state <= RFL_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Timer zeroes at launch, so time 0 is the first sample taken with the pulse on the line.
   // It stops at 255, where the run ends, so a stale count can never wrap into the window.
   always_ff @(posedge clock) begin
      if (srst || launch) begin
         timer <= 8'h00;
      end else if (running && sample_valid && (timer != LAST_TIME)) begin
         timer <= timer + 8'h01;
      end
   end

   // Pulse length counter; a zero width never starts a pulse.
   always_ff @(posedge clock) begin
      if (srst) begin
         pulse_active <= 1'b0;
         pulse_count <= 4'h0;
      end else if (launch) begin
         pulse_active <= !width_zero;
         pulse_count <= launch_count;
      end else if (pulse_last || !enable_next) begin
         pulse_active <= 1'b0;
         pulse_count <= 4'h0;
      end else if (pulse_active && pulse_tick) begin
         pulse_count <= pulse_count - 4'h1;
      end
   end

   // Fast pulses flip polarity after each one actually sent.
   always_ff @(posedge clock) begin
      if (srst) begin
         fast_polarity <= 1'b0;
      end else if (launch && written_ctrl.fast_driver_select && !width_zero) begin
         fast_polarity <= !fast_polarity;
      end
   end

   // Driver outputs. The polarity shown during a pulse is the one held before the flip,
   // so the first fast pulse after reset is positive.
   always_ff @(posedge clock) begin
      if (srst) begin
         slow_line_driver <= 1'b0;
         fast_line_driver <= 1'b0;
         pulse_negative <= 1'b0;
      end else if (launch && !width_zero) begin
         slow_line_driver <= !written_ctrl.fast_driver_select;
         fast_line_driver <= written_ctrl.fast_driver_select;
         pulse_negative <= written_ctrl.fast_driver_select && fast_polarity;
      end else if (pulse_last || !enable_next) begin
         slow_line_driver <= 1'b0;
         fast_line_driver <= 1'b0;
         pulse_negative <= 1'b0;
      end
   end

   // Takeover, pair routing and busy are registered from the next control and run state, so they change on the same edge.
   always_ff @(posedge clock) begin
      if (srst) begin
         driver_takeover <= 1'b0;
         pulse_on_rx_pair <= 1'b0;
         monitor_busy <= 1'b0;
      end else begin
         driver_takeover <= enable_next;
         pulse_on_rx_pair <= write_control ? written_ctrl.pulse_rx_pair : ctrl.pulse_rx_pair;
         monitor_busy <= (next_state == RFL_RUN);
      end
   end

endmodule

//--- logic/rfl_pkg.sv
package rfl_pkg;

   // Management register addresses of the reflectometry unit.
   localparam logic [4:0] REFLECT_CONTROL_ADDR = 5'h16;
   localparam logic [4:0] REFLECT_WINDOW_ADDR = 5'h17;
   localparam logic [4:0] REFLECT_PEAK_RESULT_ADDR = 5'h18;
   localparam logic [4:0] REFLECT_THRESHOLD_RESULT_ADDR = 5'h19;

   // Field positions inside reflect_control.
   localparam int CTRL_ENABLE_BIT = 15;
   localparam int CTRL_FAST_DRIVER_SELECT_BIT = 14;
   localparam int CTRL_PULSE_RX_PAIR_BIT = 13;
   localparam int CTRL_MONITOR_RX_PAIR_BIT = 12;
   localparam int CTRL_SEND_BIT = 11;
   localparam int CTRL_WIDTH_HI = 10;
   localparam int CTRL_WIDTH_LO = 8;
   localparam int CTRL_MIN_MODE_BIT = 7;

   // Field positions inside reflect_window and the result registers.
   localparam int WIN_START_HI = 15;
   localparam int WIN_START_LO = 8;
   localparam int WIN_STOP_HI = 7;
   localparam int WIN_STOP_LO = 0;
   localparam int THR_FOUND_BIT = 15;

   // Reset values.
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [7:0] WIN_START_RESET = 8'h00;
   localparam logic [7:0] WIN_STOP_RESET = 8'hFF;

   // Timing: the design clock and the two link pulse widths of the slow driver.
   localparam int CLOCK_PERIOD_NS = 10;
   localparam int SAMPLE_PERIOD_NS = 8;
   localparam int SLOW_SHORT_PULSE_NS = 50;
   localparam int SLOW_LONG_PULSE_NS = 100;
   localparam int SLOW_SHORT_CYCLES = (SLOW_SHORT_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int SLOW_LONG_CYCLES = (SLOW_LONG_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int LAST_SAMPLE_TIME = 255;

   // Decoded view of the control register.
   typedef struct packed {
      logic enable;
      logic fast_driver_select;
      logic pulse_rx_pair;
      logic monitor_rx_pair;
      logic [2:0] width;
      logic min_mode;
   } rfl_ctrl_t;

   // One qualified converter sample with its time stamp.
   typedef struct packed {
      logic valid;
      logic [7:0] time_stamp;
      logic signed [7:0] value;
   } rfl_sample_t;

endpackage

//--- sim/cable_reflectometry_diag_bench.sv
`timescale 1ns/1ns
// Random runs checked against a sample-by-sample reference model.
module cable_reflectometry_diag_bench;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [4:0] reg_addr = 5'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [15:0] reg_rdata;
   logic sample_valid, driver_takeover, pulse_on_rx_pair, slow_line_driver, fast_line_driver, pulse_negative;
   logic monitor_busy;
   logic signed [7:0] tx_pair_sample, rx_pair_sample;
   logic signed [7:0] threshold_level = 8'h10;
   logic signed [7:0] echo_level = 8'h40;
   logic [7:0] echo_delay = 8'h20;
   logic sparse = 1'b0;
   int fail_count = 0;
   int checks = 0;
   int t, v, cyc, launch_cyc, end_cyc, pulse_len, peak, ptime, tfound, ttime;
   bit on, have;
   logic [15:0] ctrl = 16'h0000;
   logic [15:0] win = 16'h00FF;

   initial begin
      forever #5 clock = ~clock;
   end

   rfl_diag u_dut (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .sample_valid(sample_valid), .tx_pair_sample(tx_pair_sample),
      .rx_pair_sample(rx_pair_sample), .threshold_level(threshold_level), .driver_takeover(driver_takeover),
      .pulse_on_rx_pair(pulse_on_rx_pair), .slow_line_driver(slow_line_driver), .fast_line_driver(fast_line_driver),
      .pulse_negative(pulse_negative), .monitor_busy(monitor_busy));

   rfl_cable_model u_cable (.clock(clock), .sparse(sparse), .echo_delay(echo_delay), .echo_level(echo_level),
      .slow_line_driver(slow_line_driver), .fast_line_driver(fast_line_driver), .pulse_negative(pulse_negative),
      .pulse_on_rx_pair(pulse_on_rx_pair), .sample_valid(sample_valid), .tx_pair_sample(tx_pair_sample),
      .rx_pair_sample(rx_pair_sample));

   // Reference model; the timer counts samples taken after the launch edge.
   always @(posedge clock) begin
      cyc++;
      if (slow_line_driver || fast_line_driver) pulse_len++;
      if (on && sample_valid) begin
         v = ctrl[12] ? rx_pair_sample : tx_pair_sample;
         if (t == ctrl[10:8] - 1) end_cyc = cyc;
         if (t >= win[15:8] && t <= win[7:0]) begin
            if (!have || (ctrl[7] ? v < peak : v > peak)) begin
               peak = v;
               ptime = t;
            end
            have = 1;
            if (tfound == 0 && (ctrl[7] ? v < threshold_level : v > threshold_level)) begin
               tfound = 1;
               ttime = t;
            end
         end
         t++;
         if (t > 255) on = 0;
      end
      if (reg_write && reg_addr == 5'h17) win = reg_wdata;
      if (reg_write && reg_addr == 5'h16 && reg_wdata[11] && reg_wdata[15] && !on) begin
         {on, have, t, peak, ptime, tfound, ttime, pulse_len} = '0;
         on = 1;
         launch_cyc = cyc;
         ctrl = reg_wdata;
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge clock);
      reg_write = 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_read = 1'b1;
      @(negedge clock);
      reg_read = 1'b0;
      d = reg_rdata;
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Main sequence: reset values, read-only places, then random runs in every mode and width.
   initial begin
      logic [15:0] d;
      logic [15:0] r;
      logic [31:0] w;
      int k;
      void'($urandom(32'hc3ae53e4));
      repeat (12) @(negedge clock);
      srst = 1'b0;
      wr(5'h18, 16'hFFFF);
      wr(5'h1A, 16'hFFFF);
      for (int i = 0; i < 5; i++) begin
         rd(5'h16 + i[4:0], r);
         chk(r, i == 1 ? 16'h00FF : 16'h0000);
      end
      $display("reset test done");
      for (int n = 0; n < 24; n++) begin
         w = $urandom;
         d = {1'b1, w[14:12], 1'b1, w[10:7], 7'h00};
         if (n < 16) d[14:8] = {n[3], d[13:11], n[2:0]};
         sparse = w[24];
         echo_delay = {1'b0, w[31:25]};
         echo_level = {2'b01, w[5:0]};
         threshold_level = w[23:16];
         // Software side: every run of the series gets its own window before its launch.
         wr(5'h17, {2'b00, w[21:16], w[31:24]});
         rd(5'h17, r);
         chk(r, {2'b00, w[21:16], w[31:24]});
         wr(5'h16, d);
         wr(5'h16, d);
         for (k = 0; k < 1200 && monitor_busy !== 1'b0; k++) @(negedge clock);
         if (k == 1200) begin
            fail_count++;
            final_report();
         end
         rd(5'h16, r);
         chk(r, d & 16'hF7FF);
         rd(5'h18, r);
         chk(r, {ptime[7:0], peak[7:0]});
         rd(5'h19, r);
         chk(r, {tfound[0], 7'h00, ttime[7:0]});
         k = d[10:8] == 3'h0 ? 0 : d[14] ? end_cyc - launch_cyc :
            d[10] ? rfl_pkg::SLOW_LONG_CYCLES : rfl_pkg::SLOW_SHORT_CYCLES;
         chk(pulse_len[15:0], k[15:0]);
         $display("run %0d done", n);
      end
      // Clearing the enable in mid-pulse must hand the drivers back at once and end the run.
      wr(5'h16, 16'h8C00);
      chk({14'h0000, driver_takeover, slow_line_driver}, 16'h0003);
      wr(5'h16, 16'h0000);
      chk({14'h0000, driver_takeover, slow_line_driver}, 16'h0000);
      @(negedge clock);
      chk({15'h0000, monitor_busy}, 16'h0000);
      $display("abort test done");
      final_report();
   end
endmodule

//--- sim/rfl_cable_model.sv
`timescale 1ns/1ns
// Cable stand-in: noise on both pairs and one echo some cycles after each pulse.
module rfl_cable_model (
   input wire logic clock,
   input wire logic sparse,
   input wire logic [7:0] echo_delay,
   input wire logic signed [7:0] echo_level,
   input wire logic slow_line_driver,
   input wire logic fast_line_driver,
   input wire logic pulse_negative,
   input wire logic pulse_on_rx_pair,
   output logic sample_valid,
   output logic signed [7:0] tx_pair_sample,
   output logic signed [7:0] rx_pair_sample
);
   logic [15:0] noise = 16'hACE1;
   logic [7:0] age = 8'hFF;
   logic drv_d = 1'b0;
   logic neg = 1'b0;
   wire drv = slow_line_driver || fast_line_driver;
   wire echo = age >= echo_delay && age < echo_delay + 8'h04;
   wire signed [7:0] lvl = neg ? -echo_level : echo_level;
   // Values move at the falling edge so they are steady when the converter is sampled.
   always @(negedge clock) begin
      noise <= {noise[14:0], noise[15] ^ noise[13] ^ noise[12] ^ noise[10]};
      drv_d <= drv;
      sample_valid <= !sparse || noise[0];
      if (drv && !drv_d) begin
         age <= 8'h00;
         neg <= pulse_negative;
      end else if (age != 8'hFF) begin
         age <= age + 8'h01;
      end
      tx_pair_sample <= (echo && !pulse_on_rx_pair) ? lvl : $signed(noise[7:0]) >>> 3;
      rx_pair_sample <= (echo && pulse_on_rx_pair) ? lvl : $signed(noise[15:8]) >>> 3;
   end
endmodule

//--- sim/rfl_diag_props.sv
`timescale 1ns/1ns
// Port-level checks on the control writes and the line driver outputs.
module rfl_diag_props (
   input wire logic clock,
   input wire logic srst,
   input wire logic [4:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [15:0] reg_rdata,
   input wire logic driver_takeover,
   input wire logic pulse_on_rx_pair,
   input wire logic slow_line_driver,
   input wire logic fast_line_driver,
   input wire logic pulse_negative,
   input wire logic monitor_busy
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   // A launch is a control write with send and enable set while no run is going.
   wire ctl_wr = reg_write && reg_addr == rfl_pkg::REFLECT_CONTROL_ADDR;
   wire go = ctl_wr && reg_wdata[11] && reg_wdata[15] && !monitor_busy;
   wire pulse = slow_line_driver || fast_line_driver;
   logic last_neg;
   logic seen;
   // Keeps the polarity of the last fast pulse, since alternation spans runs.
   always_ff @(posedge clock) begin
      if (srst) begin
         last_neg <= 1'b0;
         seen <= 1'b0;
      end else if ($rose(fast_line_driver)) begin
         last_neg <= pulse_negative;
         seen <= 1'b1;
      end
   end
   AST_TAKEOVER: assert property (ctl_wr |=> driver_takeover == $past(reg_wdata[15]))
      else $error("takeover does not follow enable bit");
   AST_IDLE_DRIVERS: assert property (!driver_takeover |-> !pulse)
      else $error("driver active without takeover");
   AST_RX_PAIR: assert property (ctl_wr |=> pulse_on_rx_pair == $past(reg_wdata[13]))
      else $error("pulse pair select wrong");
   AST_LAUNCH: assert property (go |=> monitor_busy)
      else $error("launch did not start monitor");
   AST_ZERO: assert property (go && reg_wdata[10:8] == 3'h0 |=> !pulse [*4])
      else $error("pulse sent with zero width");
   AST_FAST: assert property (go && reg_wdata[14] && reg_wdata[10:8] != 3'h0 |=>
      fast_line_driver && !slow_line_driver)
      else $error("fast driver not selected");
   AST_SLOW_LONG: assert property (go && !reg_wdata[14] && reg_wdata[10] |=>
      slow_line_driver [*8] ##1 slow_line_driver [*2] ##1 !slow_line_driver)
      else $error("long slow pulse not 100 ns");
   AST_SLOW_SHORT: assert property (go && !reg_wdata[14] && !reg_wdata[10] && reg_wdata[9:8] != 2'h0 |=>
      slow_line_driver [*5] ##1 !slow_line_driver)
      else $error("short slow pulse not 50 ns");
   AST_POLARITY: assert property ($rose(fast_line_driver) |-> pulse_negative == (seen && !last_neg))
      else $error("fast pulse polarity did not alternate");
   AST_NEG_FAST: assert property (pulse_negative |-> fast_line_driver)
      else $error("negative flag outside fast pulse");
   AST_RDATA_HOLD: assert property (!reg_read |=> $stable(reg_rdata))
      else $error("read data changed without read");
   COV_FAST: cover property (go && reg_wdata[14] && reg_wdata[10:8] == 3'h7);
   COV_SLOW: cover property (go && !reg_wdata[14] && reg_wdata[10]);
   COV_ZERO: cover property (go && reg_wdata[10:8] == 3'h0);
endmodule
bind rfl_diag rfl_diag_props u_props (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .driver_takeover(driver_takeover),
   .pulse_on_rx_pair(pulse_on_rx_pair), .slow_line_driver(slow_line_driver), .fast_line_driver(fast_line_driver),
   .pulse_negative(pulse_negative), .monitor_busy(monitor_busy));
